// >>> logic/ouv_down_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ouv_down_timer #(
    parameter int W = 27
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    input  wire logic         step,
    // Status
    output logic              done
);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb
    begin
        next_cnt = cnt;
        if (load)
            next_cnt = value;
        else if (step && (cnt != '0))
            next_cnt = cnt - W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end

    assign done = (cnt == '0);

endmodule
`default_nettype wire

// >>> logic/ouv_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ouv_monitor
    import ouv_pkg::*;
#(
    parameter int TW = 24
)
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Command port
    input  wire ouv_cmd_t      cmd,
    output logic      [15:0]   rsp_data,
    output logic               rsp_valid,
    // Converter side
    input  wire logic [15:0]   vout_command,
    input  wire logic          vout_relative,
    input  wire logic [15:0]   sensed_vout,
    input  wire logic          pwm_tick,
    input  wire logic [TW-1:0] ton_rise_cycles,
    input  wire logic [TW-1:0] ton_max_cycles,
    input  wire logic          ton_max_enable,
    input  wire logic          commanded_on,
    input  wire logic          clear_faults,
    // Status and control out
    output ouv_status_t        status,
    output logic               host_alert,
    output logic               power_enable
);

    localparam int TMW = TW + 3;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ouv_state_e  st;
        logic [15:0] warn_word;
        logic [9:0]  warn_pm;
        logic [15:0] fault_word;
        logic [9:0]  fault_pm;
        logic [7:0]  action;
        logic [2:0]  tries;
        ouv_status_t status;
        logic        alert;
        logic        pwr;
        logic [15:0] rdata;
        logic        rvalid;
    } ouv_regs_t;

    ouv_regs_t r;
    ouv_regs_t n;

    logic [9:0]     warn_q;
    logic           warn_ok;
    logic [9:0]     fault_q;
    logic           fault_ok;
    logic [25:0]    warn_prod;
    logic [25:0]    fault_prod;
    logic [15:0]    warn_thr;
    logic [15:0]    fault_thr;
    logic           warn_low;
    logic           fault_low;
    logic           monitoring;
    logic [1:0]     resp;
    logic [2:0]     retry;
    logic [2:0]     dly;
    logic           fault_act;
    logic           exhausted;
    logic [3:0]     dly_ticks;
    logic [2:0]     mult;
    logic [TMW-1:0] restart_wait_period;
    logic           tmr_load;
    logic [TMW-1:0] tmr_val;
    logic           tmr_step;
    logic           tmr_done;
    logic           wr;
    logic           rd;
    logic           set_cml;

    // ----------------------------------------------------------------
    // Value mapping and timing
    // ----------------------------------------------------------------
    ouv_pct_map #(
        .MIN_PM  (WARN_MIN_PM),
        .MAX_PM  (WARN_MAX_PM),
        .STEP_PM (WARN_STEP_PM)
    ) u_warn_map (
        .word     (cmd.data),
        .vout_cmd (vout_command),
        .relative (vout_relative),
        .pm_q     (warn_q),
        .ok       (warn_ok)
    );

    // Fault limit is always absolute
    ouv_pct_map #(
        .MIN_PM  (FAULT_MIN_PM),
        .MAX_PM  (FAULT_MAX_PM),
        .STEP_PM (FAULT_STEP_PM)
    ) u_fault_map (
        .word     (cmd.data),
        .vout_cmd (vout_command),
        .relative (1'b0),
        .pm_q     (fault_q),
        .ok       (fault_ok)
    );

    // One timer serves delay, wait, ramp and check; phases never overlap
    ouv_down_timer #(
        .W (TMW)
    ) u_timer (
        .clk   (clk),
        .rst   (rst),
        .load  (tmr_load),
        .value (tmr_val),
        .step  (tmr_step),
        .done  (tmr_done)
    );

    // ----------------------------------------------------------------
    // Comparators and decode
    // ----------------------------------------------------------------
    always_comb
    begin
        // Thresholds follow the commanded output, stored words do not
        warn_prod  = 26'(vout_command) * 26'(r.warn_pm);
        fault_prod = 26'(vout_command) * 26'(r.fault_pm);
        warn_thr   = 16'(warn_prod / 26'(PM_SCALE));
        fault_thr  = 16'(fault_prod / 26'(PM_SCALE));
        warn_low   = sensed_vout < warn_thr;
        fault_low  = sensed_vout < fault_thr;
        // Ramp is blind: the output is legitimately low while rising
        monitoring = (r.st == ST_RUN) || (r.st == ST_DELAY) || (r.st == ST_CHECK);
        resp       = r.action[ACT_RESP_LSB +: 2];
        retry      = r.action[ACT_RETRY_LSB +: 3];
        dly        = r.action[ACT_DLY_LSB +: 3];
        fault_act  = fault_low && ((resp == RESP_DELAYED) || (resp == RESP_NOW));
        exhausted  = (retry == RETRY_LATCH) || ((retry != RETRY_FOREVER) && (r.tries >= retry));
        if (dly <= DLY_ONE_MAX)
            dly_ticks = TICKS_ONE;
        else if (dly <= DLY_THREE_MAX)
            dly_ticks = TICKS_THREE;
        else
            dly_ticks = TICKS_SEVEN;
        // Code zero still waits one rise time
        mult       = (dly == 3'h0) ? 3'h1 : dly;
        restart_wait_period     = TMW'(mult) * TMW'(ton_rise_cycles);
        wr         = cmd.valid && cmd.write;
        rd         = cmd.valid && !cmd.write;
        tmr_step   = (r.st == ST_DELAY) ? pwm_tick : 1'b1;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n        = r;
        n.rvalid = 1'b0;
        set_cml  = 1'b0;
        tmr_load = 1'b0;
        tmr_val  = '0;

        // Writes land at once, also while converting
        if (wr && (cmd.code == CMD_UV_WARN))
        begin
            if (warn_ok)
            begin
                n.warn_word = cmd.data;
                n.warn_pm   = warn_q;
            end
            else
                set_cml = 1'b1;
        end
        if (wr && (cmd.code == CMD_UV_FAULT))
        begin
            if (fault_ok)
            begin
                n.fault_word = cmd.data;
                n.fault_pm   = fault_q;
            end
            else
                set_cml = 1'b1;
        end
        if (wr && (cmd.code == CMD_UV_ACTION))
        begin
            if ((cmd.data[ACT_RESP_LSB +: 2] == RESP_INVALID) || (cmd.data[15:8] != 8'h00))
                set_cml = 1'b1;
            else
                n.action = cmd.data[7:0];
        end

        // Reads answer one cycle later; other codes belong elsewhere
        if (rd)
        begin
            case (cmd.code)
                CMD_UV_WARN:
                begin
                    n.rdata  = r.warn_word;
                    n.rvalid = 1'b1;
                end
                CMD_UV_FAULT:
                begin
                    n.rdata  = r.fault_word;
                    n.rvalid = 1'b1;
                end
                CMD_UV_ACTION:
                begin
                    n.rdata  = {8'h00, r.action};
                    n.rvalid = 1'b1;
                end
                default:
                begin
                    n.rdata  = r.rdata;
                end
            endcase
        end

        // Status: clear first, then set, so a new event survives a clear
        if (clear_faults)
            n.status = '0;
        if (set_cml)
        begin
            n.status.cml_invalid = 1'b1;
            n.status.byte_cml    = 1'b1;
        end
        if (monitoring && warn_low)
        begin
            n.status.vout_uv_warn = 1'b1;
            n.status.word_vout    = 1'b1;
        end
        if (monitoring && fault_low)
        begin
            n.status.vout_uv_fault   = 1'b1;
            n.status.byte_none_above = 1'b1;
            n.status.word_vout       = 1'b1;
        end

        // Supervision sequence
        case (r.st)
            ST_OFF:
            begin
                if (commanded_on)
                begin
                    n.st     = ST_RAMP;
                    tmr_load = 1'b1;
                    tmr_val  = TMW'(ton_rise_cycles);
                end
            end
            ST_RUN, ST_CHECK:
            begin
                if (fault_act && (resp == RESP_DELAYED))
                begin
                    n.st     = ST_DELAY;
                    tmr_load = 1'b1;
                    tmr_val  = TMW'(dly_ticks);
                end
                else if (fault_act && exhausted)
                    n.st = ST_LATCH;
                else if (fault_act)
                begin
                    n.st     = ST_WAIT;
                    tmr_load = 1'b1;
                    tmr_val  = restart_wait_period;
                end
                else if ((r.st == ST_CHECK) && tmr_done)
                begin
                    n.st    = ST_RUN;
                    n.tries = 3'h0;
                end
            end
            ST_DELAY:
            begin
                if (tmr_done && exhausted)
                    n.st = ST_LATCH;
                else if (tmr_done)
                begin
                    n.st     = ST_WAIT;
                    tmr_load = 1'b1;
                    tmr_val  = restart_wait_period;
                end
            end
            ST_WAIT:
            begin
                if (tmr_done)
                begin
                    n.st     = ST_RAMP;
                    tmr_load = 1'b1;
                    tmr_val  = TMW'(ton_rise_cycles);
                    if (r.tries != RETRY_FOREVER)
                        n.tries = 3'(r.tries + 3'h1);
                end
            end
            ST_RAMP:
            begin
                if (tmr_done)
                begin
                    n.st     = ST_CHECK;
                    tmr_load = 1'b1;
                    tmr_val  = ton_max_enable ? TMW'(ton_max_cycles) : TMW'(ton_rise_cycles);
                end
            end
            ST_LATCH:
            begin
                n.st = ST_LATCH;
            end
            default:
            begin
                n.st = ST_OFF;
            end
        endcase

        // Commanding off ends any sequence and forgets past attempts
        if (!commanded_on)
        begin
            n.st    = ST_OFF;
            n.tries = 3'h0;
        end

        n.pwr   = (n.st == ST_RUN) || (n.st == ST_DELAY) || (n.st == ST_RAMP) || (n.st == ST_CHECK);
        n.alert = (n.status != '0);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r            <= '0;
            r.st         <= ST_OFF;
            r.warn_word  <= RST_WARN_WORD;
            r.warn_pm    <= RST_WARN_PM;
            r.fault_word <= RST_FAULT_WORD;
            r.fault_pm   <= RST_FAULT_PM;
            r.action     <= RST_ACTION;
        end
        else
            r <= n;
    end

    assign rsp_data     = r.rdata;
    assign rsp_valid    = r.rvalid;
    assign status       = r.status;
    assign host_alert   = r.alert;
    assign power_enable = r.pwr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_read_warn;
        rd && (cmd.code == CMD_UV_WARN) |=> rsp_valid && (rsp_data == $past(r.warn_word));
    endproperty
    a_read_warn: assert property (p_read_warn) else $error("warning limit read mismatch");

    property p_warn_flag;
        monitoring && warn_low && !clear_faults |=> status.vout_uv_warn && status.word_vout && host_alert;
    endproperty
    a_warn_flag: assert property (p_warn_flag) else $error("low warning not flagged");

    property p_warn_grid;
        (r.warn_pm >= WARN_MIN_PM) && (r.warn_pm <= WARN_MAX_PM)
            && (((r.warn_pm - WARN_MIN_PM) % WARN_STEP_PM) == 10'h000);
    endproperty
    a_warn_grid: assert property (p_warn_grid) else $error("warning step off grid");

    property p_words_hold;
        !wr |=> $stable(r.warn_word) && $stable(r.fault_word) && $stable(r.action);
    endproperty
    a_words_hold: assert property (p_words_hold) else $error("limit changed without write");

    property p_live_write;
        wr && (cmd.code == CMD_UV_FAULT) && fault_ok && r.pwr && (r.st != ST_DELAY) && commanded_on && !fault_act
            |=> (r.fault_word == $past(cmd.data)) && power_enable;
    endproperty
    a_live_write: assert property (p_live_write) else $error("write did not take effect live");

    property p_fault_grid;
        (r.fault_pm >= FAULT_MIN_PM) && (r.fault_pm <= FAULT_MAX_PM)
            && (((r.fault_pm - FAULT_MIN_PM) % FAULT_STEP_PM) == 10'h000);
    endproperty
    a_fault_grid: assert property (p_fault_grid) else $error("fault step off grid");

    property p_invalid;
        wr && (cmd.code == CMD_UV_FAULT) && !fault_ok
            |=> status.cml_invalid && host_alert && $stable(r.fault_word);
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid write not refused");

    property p_fault_flags;
        monitoring && fault_low && !clear_faults
            |=> status.vout_uv_fault && status.byte_none_above && status.word_vout;
    endproperty
    a_fault_flags: assert property (p_fault_flags) else $error("fault flags missing");

    property p_immediate;
        (r.st == ST_RUN) && fault_low && (resp == RESP_NOW) |=> !power_enable;
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate shutdown missed");

    property p_ignore;
        (r.st == ST_RUN) && (resp == RESP_IGNORE) && commanded_on |=> power_enable;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore response shut down");

    property p_latch;
        (r.st == ST_LATCH) && commanded_on |=> (r.st == ST_LATCH) && !power_enable;
    endproperty
    a_latch: assert property (p_latch) else $error("latched off state left");

    property p_short_delay;
        (r.st == ST_RUN) && fault_low && (resp == RESP_DELAYED) && (dly <= DLY_ONE_MAX) && commanded_on
            |=> power_enable ##1 ((r.st == ST_DELAY) [*1]);
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("delayed shutdown too early");

    property p_success;
        (r.st == ST_CHECK) && tmr_done && !fault_act && commanded_on |=> (r.tries == 3'h0) && (r.st == ST_RUN);
    endproperty
    a_success: assert property (p_success) else $error("successful restart not recognised");

    property p_count;
        (r.st == ST_WAIT) && tmr_done && commanded_on && (r.tries != RETRY_FOREVER)
            |=> r.tries == 3'($past(r.tries) + 3'h1);
    endproperty
    a_count: assert property (p_count) else $error("restart count not advanced");

    c_delayed: cover property ((r.st == ST_RUN) ##1 (r.st == ST_DELAY));
    c_restart: cover property ((r.st == ST_WAIT) ##1 (r.st == ST_RAMP));
    c_latch:   cover property ((r.st == ST_DELAY) ##1 (r.st == ST_LATCH));
    c_recover: cover property ((r.st == ST_CHECK) ##1 (r.st == ST_RUN));

endmodule
`default_nettype wire

// >>> logic/ouv_pct_map.sv
`timescale 1ns/1ps
`default_nettype none
module ouv_pct_map
    import ouv_pkg::*;
#(
    parameter logic [9:0] MIN_PM  = 10'h000,
    parameter logic [9:0] MAX_PM  = 10'h3E8,
    parameter logic [9:0] STEP_PM = 10'h001
)
(
    // Written value and reference
    input  wire logic [15:0] word,
    input  wire logic [15:0] vout_cmd,
    input  wire logic        relative,
    // Hardware step
    output logic      [9:0]  pm_q,
    output logic             ok
);

    logic [31:0] raw;
    logic [31:0] offs;
    logic [31:0] q;

    always_comb
    begin
        // Zero reference cannot be mapped, so it falls out of range
        if (relative)
            raw = 32'(word);
        else if (vout_cmd == 16'h0000)
            raw = 32'hFFFFFFFF;
        else
            raw = (32'(word) * 32'(PM_SCALE)) / 32'(vout_cmd);
        ok   = (raw >= 32'(MIN_PM)) && (raw <= 32'(MAX_PM));
        offs = ok ? (raw - 32'(MIN_PM)) : 32'h00000000;
        // Truncating division gives the step below
        q    = 32'(MIN_PM) + (offs / 32'(STEP_PM)) * 32'(STEP_PM);
        pm_q = q[9:0];
    end

endmodule
`default_nettype wire

// >>> logic/ouv_pkg.sv
package ouv_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_UV_WARN   = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT  = 8'h44;
    localparam logic [7:0] CMD_UV_ACTION = 8'h45;

    // ----------------------------------------------------------------
    // Fault action byte layout and codes
    // ----------------------------------------------------------------
    localparam int         ACT_RESP_LSB  = 6;
    localparam int         ACT_RETRY_LSB = 3;
    localparam int         ACT_DLY_LSB   = 0;
    localparam logic [1:0] RESP_IGNORE   = 2'h0;
    localparam logic [1:0] RESP_DELAYED  = 2'h1;
    localparam logic [1:0] RESP_NOW      = 2'h2;
    localparam logic [1:0] RESP_INVALID  = 2'h3;
    localparam logic [2:0] RETRY_LATCH   = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [2:0] DLY_ONE_MAX   = 3'h1;
    localparam logic [2:0] DLY_THREE_MAX = 3'h4;
    localparam logic [3:0] TICKS_ONE     = 4'h1;
    localparam logic [3:0] TICKS_THREE   = 4'h3;
    localparam logic [3:0] TICKS_SEVEN   = 4'h7;

    // ----------------------------------------------------------------
    // Threshold grids in tenths of a percent of the commanded output
    // ----------------------------------------------------------------
    localparam logic [9:0] PM_SCALE      = 10'h3E8;
    localparam logic [9:0] WARN_MIN_PM   = 10'h348;
    localparam logic [9:0] WARN_MAX_PM   = 10'h3CA;
    localparam logic [9:0] WARN_STEP_PM  = 10'h00A;
    localparam logic [9:0] FAULT_MIN_PM  = 10'h258;
    localparam logic [9:0] FAULT_MAX_PM  = 10'h3B6;
    localparam logic [9:0] FAULT_STEP_PM = 10'h019;

    // ----------------------------------------------------------------
    // Reset values standing in for the stored copies
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_WARN_WORD  = 16'h0384;
    localparam logic [9:0]  RST_WARN_PM    = 10'h384;
    localparam logic [15:0] RST_FAULT_WORD = 16'h0352;
    localparam logic [9:0]  RST_FAULT_PM   = 10'h352;
    localparam logic [7:0]  RST_ACTION     = 8'h80;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_RAMP  = 3'h1,
        ST_CHECK = 3'h3,
        ST_RUN   = 3'h2,
        ST_DELAY = 3'h6,
        ST_WAIT  = 3'h7,
        ST_LATCH = 3'h5
    } ouv_state_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } ouv_cmd_t;

    typedef struct packed {
        logic word_vout;
        logic byte_none_above;
        logic byte_cml;
        logic cml_invalid;
        logic vout_uv_warn;
        logic vout_uv_fault;
    } ouv_status_t;

endpackage

// >>> test/ouv_host.sv
`timescale 1ns/1ps
`default_nettype none
module ouv_host
    import ouv_pkg::*;
(
    // Bus side
    input  wire logic        clk,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rsp_valid,
    output var  ouv_cmd_t    cmd
);
    initial cmd = '{1'b0, 1'b0, 8'h00, 16'hA5A5};
    // Held for one edge, then idle for one so calls never collide; idle data inverted
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [16:0] r);
    begin
        cmd = '{1'b1, w, c, d};
        @(posedge clk);
        #1;
        cmd = '{1'b0, 1'b0, 8'h00, ~d};
        r = {rsp_valid, rsp_data};
        @(posedge clk);
        #1;
    end
    endtask
endmodule
`default_nettype wire

// >>> test/test_ouv_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_ouv_monitor;
    import ouv_pkg::*;
    logic clk, rst, rsp_valid, rel, tick, on, clr, alert, pwr, tmax;
    logic [15:0] rsp_data, vcmd, sensed;
    logic [16:0] r;
    ouv_cmd_t cmd;
    ouv_status_t status;
    int num_errors, n_checks;
    ouv_monitor #(.TW(24)) ouv_monitor_inst (.clk(clk), .rst(rst), .cmd(cmd), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .vout_command(vcmd), .vout_relative(rel), .sensed_vout(sensed),
        .pwm_tick(tick), .ton_rise_cycles(24'h000004), .ton_max_cycles(24'h000010), .ton_max_enable(tmax),
        .commanded_on(on), .clear_faults(clr), .status(status), .host_alert(alert), .power_enable(pwr));
    ouv_host ouv_host_inst (.clk(clk), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .cmd(cmd));
    initial
    begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // One PWM period every four clocks
    initial
    begin
        tick = 0;
        forever
        begin
            cyc(3);
            tick = 1;
            cyc(1);
            tick = 0;
        end
    end
    task automatic chk(input string n, input logic [16:0] g, input logic [16:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        ouv_host_inst.xfer(1'b0, c, 16'h0000, r);
        chk("read", r, {1'b1, e});
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        ouv_host_inst.xfer(1'b1, c, d, r);
    endtask
    task automatic clear();
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        // Generous span; the tests take a few hundred cycles
        #20000;
        num_errors++;
        conclude();
    end
    initial
    begin
        {rst, rel, tmax, on, clr} = 5'h10;
        vcmd = 16'h03E8;
        sensed = 16'h03E8;
        cyc(2);
        rst = 0;
        rd(CMD_UV_WARN, 16'h0384);
        rd(CMD_UV_FAULT, 16'h0352);
        rd(CMD_UV_ACTION, 16'h0080);
        $display("test reset done");
        vcmd = 16'h07D0;
        wr(CMD_UV_WARN, 16'h0708);
        rd(CMD_UV_WARN, 16'h0708);
        vcmd = 16'h03E8;
        rel = 1;
        wr(CMD_UV_WARN, 16'h03C5);
        rd(CMD_UV_WARN, 16'h03C5);
        wr(CMD_UV_WARN, 16'h0320);
        cyc(1);
        chk("refuse", {status, alert}, 17'h19);
        rd(CMD_UV_WARN, 16'h03C5);
        clear();
        chk("clear", {status, alert}, 17'h00);
        wr(CMD_UV_FAULT, 16'h02F3);
        wr(CMD_UV_FAULT, 16'h03C0);
        rd(CMD_UV_FAULT, 16'h02F3);
        wr(CMD_UV_ACTION, 16'h00C0);
        rd(CMD_UV_ACTION, 16'h0080);
        vcmd = 16'h0400;
        rd(CMD_UV_FAULT, 16'h02F3);
        vcmd = 16'h03E8;
        clear();
        $display("test limits done");
        // Just under the written level but above the rounded step
        sensed = 16'h03C1;
        on = 1;
        cyc(20);
        chk("run", {status, pwr}, 17'h01);
        sensed = 16'h03B6;
        cyc(3);
        chk("warn", {status, alert}, 17'h45);
        sensed = 16'h03C1;
        clear();
        sensed = 16'h02F0;
        cyc(3);
        chk("nofault", {status, pwr}, 17'h45);
        sensed = 16'h02BC;
        cyc(3);
        chk("fault", {status, pwr}, 17'h66);
        cyc(30);
        chk("latch", pwr, 0);
        $display("test supervision done");
        on = 0;
        sensed = 16'h03C1;
        cyc(2);
        clear();
        wr(CMD_UV_ACTION, 16'h0052);
        on = 1;
        cyc(20);
        wr(CMD_UV_FAULT, 16'h0258);
        rd(CMD_UV_FAULT, 16'h0258);
        sensed = 16'h02BC;
        cyc(3);
        chk("live", {status, pwr}, 17'h45);
        sensed = 16'h0200;
        cyc(3);
        chk("delay", {status, pwr}, 17'h67);
        cyc(150);
        chk("retry latch", pwr, 0);
        on = 0;
        sensed = 16'h03C1;
        cyc(2);
        clear();
        wr(CMD_UV_ACTION, 16'h0000);
        on = 1;
        cyc(20);
        sensed = 16'h0200;
        cyc(10);
        chk("ignore", {status, pwr}, 17'h67);
        on = 0;
        sensed = 16'h03C1;
        cyc(2);
        wr(CMD_UV_ACTION, 16'h0079);
        tmax = 1;
        on = 1;
        cyc(40);
        sensed = 16'h0200;
        cyc(150);
        sensed = 16'h03C1;
        cyc(60);
        chk("forever", {status, pwr}, 17'h67);
        $display("test response done");
        conclude();
    end
endmodule
`default_nettype wire
